// ---- logic/spc_pkg.sv ----
// Purpose: shared constants for the system pll control block
// Assumes: apb slave, 32-bit data, word aligned registers
// Notes:   offsets and key values below are local choices
package spc_pkg;
    // =====================================================================
    // register map
    localparam logic [11:0] SPC_OFF_CTRL   = 12'h000;
    localparam logic [11:0] SPC_OFF_UNLOCK = 12'h004;
    localparam logic [11:0] SPC_OFF_STATUS = 12'h008;
    // =====================================================================
    // control field positions
    localparam int SPC_DIV_LSB   = 8;
    localparam int SPC_REF_BIT   = 7;
    localparam int SPC_BAND_LSB  = 0;
    // =====================================================================
    // unlock keys, written in order to the unlock register
    localparam logic [31:0] SPC_KEY_ONE = 32'haa99_6655;
    localparam logic [31:0] SPC_KEY_TWO = 32'h5566_99aa;
    // =====================================================================
    // codes
    localparam logic [2:0] SPC_SRC_PLL     = 3'h1;
    localparam logic [2:0] SPC_BAND_BYPASS = 3'h0;
    localparam logic [2:0] SPC_BAND_MAX    = 3'h5;
    localparam logic [2:0] SPC_DIV_ONE     = 3'h0;
    // =====================================================================
    // unlock state machine
    typedef enum logic [1:0] {
        SPC_LOCKED   = 2'b00,
        SPC_HALF     = 2'b01,
        SPC_UNLOCKED = 2'b11
    } spc_lock_e;
endpackage : spc_pkg

// ---- logic/spc_sync.sv ----
// Purpose: three stage synchroniser for pin inputs
// Assumes: input is asynchronous to clk_sys_in
// Notes:   output changes when the second and third stage agree
`timescale 1ns/1ns
module spc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_b_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    // =====================================================================
    // stages
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;

    // first stage feeds only the second
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else if (ce_in) begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_r <= s3_r; // accept only settled value
            end
        end
    end
    assign q_out = q_r;
endmodule : spc_sync

// ---- logic/spc_top.sv ----
// Purpose: control register for the system phase locked loop
// Assumes: apb master keeps request stable until pready
// Notes:   nonvolatile defaults are loaded on the first enabled edge after reset
// How it works
// - the reference divide ratio is the divider field plus one.
// - with the fast rc reference chosen the divider field is ignored and divide by one used.
// - reference select 1 routes the fast rc oscillator, 0 the primary oscillator.
// - band 000 bypasses, 001 to 101 pick bands, 110 and 111 are reserved.
// - after power-on reset the three fields load from the nonvolatile defaults.
// - a write to the control register takes effect only after the unlock sequence.
// - writes are blocked while the current clock source field is 001.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
module spc_top
    import spc_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    input  wire logic        ce_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [2:0]  cfg_default_input_divider_in,
    input  wire logic        cfg_default_reference_select_in,
    input  wire logic [2:0]  cfg_default_frequency_band_in,
    input  wire logic [2:0]  current_clock_source_in,
    output logic             pll_reference_select_out,
    output logic [2:0]       pll_input_divider_out,
    output logic [3:0]       pll_divide_ratio_out,
    output logic [2:0]       pll_frequency_band_out,
    output logic             pll_bypass_out,
    output logic             pll_band_reserved_out,
    output logic             pll_ref_fast_rc_out,
    output logic             pll_ref_primary_out
);
    import spc_pkg::*;

    // =====================================================================
    // state
    typedef struct packed {
        logic        loaded;
        spc_lock_e   lock;
        logic        ref_sel;
        logic [2:0]  div;
        logic [2:0]  band;
        logic        refused;
        logic [31:0] rdata;
        logic        slverr;
    } spc_state_s;

    spc_state_s st_r;
    spc_state_s st_nxt;
    logic [2:0] cur_src;

    // clock source comes from another domain
    spc_sync #(.W(3)) u_src_sync (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .ce_in      (ce_in),
        .d_in       (current_clock_source_in),
        .q_out      (cur_src)
    );

    // effective divide ratio, shared by output and read path
    function automatic logic [3:0] spc_ratio(input logic ref_sel, input logic [2:0] div);
        if (ref_sel) begin
            spc_ratio = 4'h1;
        end else begin
            spc_ratio = {1'b0, div} + 4'h1;
        end
    endfunction : spc_ratio

    // =====================================================================
    // bus decode
    logic       access;
    logic       taken;
    logic       rd_phase_r;
    logic       wr_ctrl;
    logic       wr_unl;
    logic       pll_active;
    logic       mapped;
    logic       wr_ref;
    logic [2:0] wr_div;
    logic [2:0] wr_band;
    assign access     = psel_in && penable_in;
    // writes act only on the edge that answers: the access phase spans two
    // edges, and acting on both would replay a key or refuse a good write
    assign taken      = access && rd_phase_r;
    // write data fields, shared by the update path and the checks
    assign wr_ref     = pwdata_in[SPC_REF_BIT];
    assign wr_div     = pwdata_in[SPC_DIV_LSB +: 3];
    assign wr_band    = pwdata_in[SPC_BAND_LSB +: 3];
    assign pll_active = (cur_src == SPC_SRC_PLL);
    assign mapped     = (paddr_in == SPC_OFF_CTRL) || (paddr_in == SPC_OFF_UNLOCK)
                     || (paddr_in == SPC_OFF_STATUS);
    assign wr_ctrl    = taken && pwrite_in && (paddr_in == SPC_OFF_CTRL);
    assign wr_unl     = taken && pwrite_in && (paddr_in == SPC_OFF_UNLOCK);

    // next state: defaults, unlock, guarded write, read data
    always_comb begin
        st_nxt = st_r;
        if (!st_r.loaded) begin
            st_nxt.loaded  = 1'b1;
            st_nxt.ref_sel = cfg_default_reference_select_in;
            st_nxt.div     = cfg_default_input_divider_in;
            st_nxt.band    = cfg_default_frequency_band_in;
        end
        if (wr_unl) begin
            case (st_r.lock)
                SPC_LOCKED:   st_nxt.lock = (pwdata_in == SPC_KEY_ONE) ? SPC_HALF : SPC_LOCKED;
                SPC_HALF:     st_nxt.lock = (pwdata_in == SPC_KEY_TWO) ? SPC_UNLOCKED
                                                                       : SPC_LOCKED;
                SPC_UNLOCKED: st_nxt.lock = (pwdata_in == SPC_KEY_ONE) ? SPC_UNLOCKED
                                                                       : SPC_LOCKED;
                default:      st_nxt.lock = SPC_LOCKED;
            endcase
        end
        if (wr_ctrl && st_r.loaded) begin
            // one write per unlock, so a stray later write cannot slip in
            st_nxt.lock = SPC_LOCKED;
            if (st_r.lock == SPC_UNLOCKED && !pll_active) begin
                st_nxt.ref_sel = wr_ref;
                st_nxt.div     = wr_div;
                st_nxt.band    = wr_band;
                st_nxt.refused = 1'b0;
            end else begin
                st_nxt.refused = 1'b1; // fields kept
            end
        end
        st_nxt.slverr = access && !mapped;
        st_nxt.rdata  = 32'h0000_0000;
        if (access && !pwrite_in) begin
            case (paddr_in)
                SPC_OFF_CTRL: begin
                    st_nxt.rdata[SPC_DIV_LSB +: 3]  = st_r.div;
                    st_nxt.rdata[SPC_REF_BIT]       = st_r.ref_sel;
                    st_nxt.rdata[SPC_BAND_LSB +: 3] = st_r.band;
                end
                SPC_OFF_STATUS: begin
                    st_nxt.rdata[1:0]  = st_r.lock;
                    st_nxt.rdata[2]    = st_r.refused;
                    st_nxt.rdata[5:3]  = cur_src;
                    st_nxt.rdata[11:8] = spc_ratio(st_r.ref_sel, st_r.div);
                end
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // register the whole state
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r <= '{loaded: 1'b0, lock: SPC_LOCKED, ref_sel: 1'b0, div: SPC_DIV_ONE,
                      band: SPC_BAND_BYPASS, refused: 1'b0, rdata: 32'h0000_0000,
                      slverr: 1'b0};
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    // =====================================================================
    // outputs; read data registered, so each access takes two access cycles
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_phase_r <= 1'b0;
        end else if (ce_in) begin
            rd_phase_r <= access && !rd_phase_r;
        end
    end
    assign pready_out  = rd_phase_r && ce_in;
    assign prdata_out  = st_r.rdata;
    assign pslverr_out = rd_phase_r && st_r.slverr;

    assign pll_reference_select_out = st_r.ref_sel;
    assign pll_input_divider_out    = st_r.div;
    assign pll_divide_ratio_out     = spc_ratio(st_r.ref_sel, st_r.div);
    assign pll_ref_fast_rc_out      = st_r.ref_sel;
    assign pll_ref_primary_out      = !st_r.ref_sel;
    assign pll_frequency_band_out   = st_r.band;
    assign pll_bypass_out           = (st_r.band == SPC_BAND_BYPASS);
    assign pll_band_reserved_out    = (st_r.band > SPC_BAND_MAX);

    // =====================================================================
    // checks
    a_fast_rc_ratio: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        st_r.ref_sel |-> pll_divide_ratio_out == 4'h1)
        else $error("fast rc reference not divide by one");
    a_div_ratio: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !st_r.ref_sel |-> pll_divide_ratio_out == {1'b0, st_r.div} + 4'h1)
        else $error("divide ratio not field plus one");
    a_ref_route: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        pll_ref_fast_rc_out != pll_ref_primary_out)
        else $error("reference routing inconsistent");
    a_band_decode: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        pll_bypass_out |-> !pll_band_reserved_out && pll_frequency_band_out == 3'h0)
        else $error("band decode wrong");
    a_default_load: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (ce_in && !st_r.loaded) |=> st_r.div == $past(cfg_default_input_divider_in)
            && st_r.band == $past(cfg_default_frequency_band_in))
        else $error("defaults not loaded");
    sequence s_locked_write;
        ce_in && wr_ctrl && st_r.loaded && st_r.lock != SPC_UNLOCKED;
    endsequence
    a_locked_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_locked_write |=> $stable(st_r.div) && $stable(st_r.band))
        else $error("locked write changed fields");
    a_pll_block: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (ce_in && wr_ctrl && st_r.loaded && pll_active) |=> $stable(st_r.ref_sel)
            && st_r.refused)
        else $error("write accepted while pll active");
    a_refuse_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_locked_write |=> st_r.refused && st_r.lock == SPC_LOCKED)
        else $error("refused write not flagged");

    // =====================================================================
    // bus handshake checks
    sequence s_first_access;
        ce_in && access && !rd_phase_r;
    endsequence

    sequence s_answer;
        !ce_in || pready_out;
    endsequence

    // the answer comes in the second access cycle, never later
    a_ready_second: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_first_access |=> s_answer)
        else $error("pready not in second access cycle");

    // pready stands one cycle, so a held request cannot be taken twice
    a_ready_once: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (ce_in && pready_out) |=> !pready_out)
        else $error("pready held longer than one cycle");

    a_err_with_ready: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (ce_in && pslverr_out) |-> pready_out)
        else $error("pslverr without pready");

    a_unmapped_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (pready_out && pslverr_out) |-> prdata_out == 32'h0000_0000)
        else $error("unmapped read data not zero");

    // =====================================================================
    // unlock and write checks
    sequence s_first_key;
        ce_in && wr_unl && st_r.lock == SPC_LOCKED && pwdata_in == SPC_KEY_ONE;
    endsequence

    sequence s_second_key;
        ce_in && wr_unl && st_r.lock == SPC_HALF && pwdata_in == SPC_KEY_TWO;
    endsequence

    sequence s_open_write;
        ce_in && wr_ctrl && st_r.loaded && st_r.lock == SPC_UNLOCKED && !pll_active;
    endsequence

    a_unlock_step: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_first_key |=> st_r.lock == SPC_HALF)
        else $error("first key not taken");

    a_unlock_done: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_second_key |=> st_r.lock == SPC_UNLOCKED)
        else $error("second key not taken");

    // an accepted write lands whole and clears the refused flag
    a_write_lands: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_open_write |=> st_r.div == $past(wr_div) && st_r.band == $past(wr_band)
            && st_r.ref_sel == $past(wr_ref) && !st_r.refused)
        else $error("unlocked write did not land");

    // every control write relocks, accepted or not
    a_write_relock: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (ce_in && wr_ctrl && st_r.loaded) |=> st_r.lock == SPC_LOCKED)
        else $error("control write left block unlocked");

    // a frozen clock enable must hold every bit of state
    a_ce_freeze: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !ce_in |=> $stable(st_r))
        else $error("state moved with clock enable low");

    // =====================================================================
    // output decode checks
    a_ratio_range: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        pll_divide_ratio_out != 4'h0 && pll_divide_ratio_out <= 4'h8)
        else $error("divide ratio out of range");

    a_band_reserved: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        pll_band_reserved_out == (pll_frequency_band_out inside {3'h6, 3'h7}))
        else $error("reserved band decode wrong");

    a_fast_rc_route: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        pll_reference_select_out |-> pll_ref_fast_rc_out && !pll_ref_primary_out)
        else $error("fast rc select not routed");

    // status shows the synchronised source that the write guard uses
    a_status_src: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (ce_in && access && !pwrite_in && paddr_in == SPC_OFF_STATUS)
            |=> prdata_out[5:3] == $past(cur_src))
        else $error("status clock source wrong");
endmodule : spc_top

// ---- sim/spc_testbench.sv ----
// Purpose: self-checking bench for the system pll control block
// Assumes: apb slave answers within 20 cycles, clock source syncs in 8
// Notes:   field settings run from a table, refusals and resets by hand
`timescale 1ns/1ns
module testbench;
    import spc_pkg::*;
    typedef struct packed {logic r; logic [2:0] d; logic [2:0] b; logic [3:0] q;} spc_row_s;
    // =====================================================================
    // signals
    logic        clk_sys, rst_b, ce, psel, penable, pwrite, pready, pslverr, err, dflt_ref;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  dflt_div, dflt_band, src, div, band;
    logic        ref_sel, fast_rc, primary, bypass, rsvd;
    logic [3:0]  ratio;
    int          fails, checked;
    int          cycles = 0;
    // ref select, divider, band, expected ratio; fast rc rows ignore the divider
    localparam spc_row_s ROWS[8] = '{'{1'b0, 3'h0, 3'h0, 4'h1}, '{1'b0, 3'h1, 3'h1, 4'h2},
        '{1'b0, 3'h2, 3'h2, 4'h3}, '{1'b1, 3'h3, 3'h3, 4'h1}, '{1'b0, 3'h4, 3'h4, 4'h5},
        '{1'b0, 3'h5, 3'h5, 4'h6}, '{1'b1, 3'h6, 3'h6, 4'h1}, '{1'b0, 3'h7, 3'h7, 4'h8}};
    spc_top spc_top_i (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .ce_in(ce), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .cfg_default_input_divider_in(dflt_div), .cfg_default_reference_select_in(dflt_ref),
        .cfg_default_frequency_band_in(dflt_band), .current_clock_source_in(src),
        .pll_reference_select_out(ref_sel), .pll_input_divider_out(div),
        .pll_divide_ratio_out(ratio), .pll_frequency_band_out(band), .pll_bypass_out(bypass),
        .pll_band_reserved_out(rsvd), .pll_ref_fast_rc_out(fast_rc),
        .pll_ref_primary_out(primary));
    // =====================================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // request held until pready is seen high, released on the next rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            fails++;
            $display("Error at %0t: no pready", $time);
        end
    endtask : apb
    task automatic unlock();
        apb(1'b1, SPC_OFF_UNLOCK, SPC_KEY_ONE);
        apb(1'b1, SPC_OFF_UNLOCK, SPC_KEY_TWO);
    endtask : unlock
    function automatic logic [31:0] ctrl(input logic r, input logic [2:0] d, input logic [2:0] b);
        return {21'h0, d, r, 4'h0, b};
    endfunction : ctrl
    // every pll output packed into one word so one compare covers them all
    task automatic outs(input logic r, input logic [2:0] d, input logic [2:0] b, input logic [3:0] q);
        @(negedge clk_sys);
        chk({17'h0, ref_sel, fast_rc, primary, div, ratio, band, bypass, rsvd},
            {17'h0, r, r, !r, d, q, b, b == 3'h0, b > 3'h5});
    endtask : outs
    task automatic give_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // =====================================================================
    // clock and hang guard, whole run needs well under 2000 cycles
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            give_verdict();
        end
    end
    // =====================================================================
    // main sequence
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, src, dflt_ref} = '0;
        ce        = 1'b1;
        dflt_div  = 3'h5;
        dflt_band = 3'h3;
        fails     = 0;
        checked   = 0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        outs(1'b0, 3'h5, 3'h3, 4'h6);
        $display("power-on defaults done");
        // reserved bits 6:3 are written as ones and must read back zero
        foreach (ROWS[i]) begin
            unlock();
            apb(1'b1, SPC_OFF_CTRL, ctrl(ROWS[i].r, ROWS[i].d, ROWS[i].b) | 32'h78);
            apb(1'b0, SPC_OFF_CTRL, 32'h0);
            chk(rd, ctrl(ROWS[i].r, ROWS[i].d, ROWS[i].b));
            outs(ROWS[i].r, ROWS[i].d, ROWS[i].b, ROWS[i].q);
        end
        $display("field table done");
        // write with no unlock, then a broken key sequence
        apb(1'b1, SPC_OFF_CTRL, ctrl(1'b1, 3'h1, 3'h1));
        apb(1'b0, SPC_OFF_STATUS, 32'h0);
        chk(rd & 32'h7, 32'h4);
        apb(1'b1, SPC_OFF_UNLOCK, SPC_KEY_ONE);
        apb(1'b1, SPC_OFF_UNLOCK, 32'h1234_5678);
        apb(1'b1, SPC_OFF_UNLOCK, SPC_KEY_TWO);
        apb(1'b1, SPC_OFF_CTRL, ctrl(1'b1, 3'h1, 3'h1));
        outs(1'b0, 3'h7, 3'h7, 4'h8);
        $display("unlock refusals done");
        // pll driving the system clock blocks even an unlocked write
        @(posedge clk_sys);
        src <= SPC_SRC_PLL;
        repeat (8) @(posedge clk_sys);
        unlock();
        apb(1'b1, SPC_OFF_CTRL, ctrl(1'b1, 3'h1, 3'h1));
        apb(1'b0, SPC_OFF_STATUS, 32'h0);
        chk(rd & 32'h3f, 32'h0c);
        outs(1'b0, 3'h7, 3'h7, 4'h8);
        @(posedge clk_sys);
        src <= 3'h2;
        repeat (8) @(posedge clk_sys);
        unlock();
        apb(1'b1, SPC_OFF_CTRL, ctrl(1'b1, 3'h1, 3'h1));
        outs(1'b1, 3'h1, 3'h1, 4'h1);
        $display("clock source block done");
        apb(1'b0, 12'h00c, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("unmapped read done");
        // second reset in mid-run with new defaults
        @(posedge clk_sys);
        rst_b     <= 1'b0;
        dflt_ref  <= 1'b1;
        dflt_div  <= 3'h2;
        dflt_band <= 3'h0;
        outs(1'b0, 3'h0, 3'h0, 4'h1);
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        outs(1'b1, 3'h2, 3'h0, 4'h1);
        $display("second reset done");
        give_verdict();
    end
endmodule : testbench
